//--- hw/isrc_regs.svh
`ifndef ISRC_REGS_SVH
`define ISRC_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ISRC_A_CTRL 8'h00
`define ISRC_A_STAT 8'h04
`define ISRC_A_DATA 8'h08
`define ISRC_A_CLK 8'h0C
`define ISRC_A_IRQ_ST 8'h10
`define ISRC_A_IRQ_MSK 8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ISRC_B_MST 7
`define ISRC_B_TRX 6
`define ISRC_B_BB 5
`define ISRC_B_PIN 4
`define ISRC_B_ACK 3
`define ISRC_B_LINE 2
`define ISRC_B_SCL 1
`define ISRC_B_LRB 0
`define ISRC_B_M_LSB 8
`define ISRC_B_N_LSB 0
`define ISRC_IRQ_WORD 0
`define ISRC_IRQ_STOP 1
`define ISRC_IRQ_RST 2

// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define ISRC_RST_M 8'h14
`define ISRC_RST_N 8'h18
`define ISRC_RST_ACK 1'b1
`define ISRC_BITS_PER_WORD 4'h8

`endif

//--- hw/isrc_pkg.sv
package isrc_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_START_HOLD,
        ST_BIT_LOW,
        ST_BIT_HIGH,
        ST_WAIT,
        ST_STOP_LOW,
        ST_STOP_REL,
        ST_STOP_HIGH,
        ST_RST_LOW,
        ST_RST_REL
    } isrc_state_e;

    typedef logic [7:0] isrc_cnt_t;
    typedef logic [7:0] isrc_addr_t;
    typedef logic [31:0] isrc_word_t;

    typedef struct packed {
        isrc_state_e state;
        isrc_cnt_t cnt;
        logic [3:0] bitn;
        logic [7:0] shift;
        logic [7:0] rx_data;
        logic master_select;
        logic trx;
        logic bb;
        logic pin;
        logic ack_en;
        logic lrb;
        logic line_busy;
        isrc_cnt_t m_val;
        isrc_cnt_t n_val;
        logic [2:0] irq_st;
        logic [2:0] irq_msk;
        logic irq;
        logic scl_drv;
        logic sda_drv;
        isrc_word_t rdata;
    } isrc_core_s;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } isrc_sync_s;

endpackage

//--- hw/isrc_sync.sv
module isrc_sync
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    import isrc_pkg::*;

    isrc_sync_s cur;
    isrc_sync_s next_cur;

    // ----------------------------------------------------------------
    // Two-stage synchroniser plus one history stage
    // ----------------------------------------------------------------
    // Reset to high: an idle open-drain line reads high, so no false edge
    always_comb
    begin
        next_cur.s1 = pin_i;
        next_cur.s2 = cur.s1;
        next_cur.s3 = cur.s2;
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            cur <= '1;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign level_o = cur.s2;
    assign rise_o = cur.s2 & ~cur.s3;
    assign fall_o = ~cur.s2 & cur.s3;

endmodule // isrc_sync

//--- hw/isrc_ctrl.sv
`include "isrc_regs.svh"
//
// Contract
// - Stop pattern written while busy starts generating a stop condition; the code acts on it only in ST_WAIT, after a word end.
// - If another device holds clock low, wait for release before stop.
// - After clock release, wait one high period before raising data.
// - Restart pattern keeps data high and releases our clock line.
// - After restart release, bus still treated as busy by others.
// - Clock low at least n, high at least m peripheral cycles.
// - Hold bus m cycles after start before first clock pulse.
// - Clock stays high m cycles before data rises for stop.
// - After pending bit goes 0 to 1, wait n cycles before clock rises.
// - Word end clears pending, holds clock low; release n after resume.
//
module isrc_ctrl
#(
    parameter int ADDR_W = 8
)
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire isrc_pkg::isrc_word_t wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output isrc_pkg::isrc_word_t rdata_o,
    output logic irq_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o
);
    import isrc_pkg::*;

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (ADDR_W < 5 || ADDR_W > 8)
    begin : g_bad_addr_w
        $error("isrc_ctrl: ADDR_W must lie between 5 and 8");
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic scl_s;
    logic sda_s;
    logic sda_rise;
    logic sda_fall;

    isrc_sync u_scl_sync
    (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .pin_i(scl_i),
        .level_o(scl_s),
        .rise_o(),
        .fall_o()
    );

    isrc_sync u_sda_sync
    (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .pin_i(sda_i),
        .level_o(sda_s),
        .rise_o(sda_rise),
        .fall_o(sda_fall)
    );

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    isrc_core_s cur;
    isrc_core_s next_cur;

    // A programmed zero would underflow; it is served as one cycle
    function automatic isrc_cnt_t load_of(input isrc_cnt_t v);
        load_of = (v == 8'h00) ? 8'h00 : v - 8'h01;
    endfunction

    isrc_addr_t addr;
    logic wr_ctrl;
    logic wr_data;
    logic wr_clk;
    logic wr_irq_st;
    logic wr_irq_msk;
    logic w_mst;
    logic w_trx;
    logic w_bb;
    logic w_pin;
    logic stop_req;
    logic rst_req;
    logic start_req;
    logic resume_req;
    logic cnt_done;
    logic [2:0] events;

    assign addr = isrc_addr_t'(addr_i);
    assign wr_ctrl = wr_i && addr == `ISRC_A_CTRL;
    assign wr_data = wr_i && addr == `ISRC_A_DATA;
    assign wr_clk = wr_i && addr == `ISRC_A_CLK;
    assign wr_irq_st = wr_i && addr == `ISRC_A_IRQ_ST;
    assign wr_irq_msk = wr_i && addr == `ISRC_A_IRQ_MSK;
    assign w_mst = wdata_i[`ISRC_B_MST];
    assign w_trx = wdata_i[`ISRC_B_TRX];
    assign w_bb = wdata_i[`ISRC_B_BB];
    assign w_pin = wdata_i[`ISRC_B_PIN];
    assign stop_req = wr_ctrl && cur.bb && w_mst && w_trx && w_pin && !w_bb;
    assign rst_req = wr_ctrl && cur.bb && !w_mst && !w_trx && w_pin && !w_bb;
    assign start_req = wr_ctrl && !cur.bb && w_mst && w_bb;
    assign resume_req = wr_data || (wr_ctrl && w_pin && !cur.pin);
    assign cnt_done = cur.cnt == 8'h00;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        next_cur = cur;
        events = 3'b000;

        // Start or stop seen on the wire while the clock is high
        if (sda_fall && scl_s)
        begin
            next_cur.line_busy = 1'b1;
        end
        else if (sda_rise && scl_s)
        begin
            next_cur.line_busy = 1'b0;
        end

        // Register writes that are legal in any state
        if (wr_ctrl)
        begin
            next_cur.ack_en = wdata_i[`ISRC_B_ACK];
        end
        if (wr_clk)
        begin
            next_cur.m_val = wdata_i[`ISRC_B_M_LSB +: 8];
            next_cur.n_val = wdata_i[`ISRC_B_N_LSB +: 8];
        end
        if (wr_irq_msk)
        begin
            next_cur.irq_msk = wdata_i[2:0];
        end

        unique case (cur.state)
            ST_IDLE,
            ST_RST_REL:
            begin
                next_cur.scl_drv = 1'b0;
                next_cur.sda_drv = 1'b0;
                if (wr_data)
                begin
                    next_cur.shift = wdata_i[7:0];
                end
                // last bit mirrors the clock line after a restart
                if (cur.state == ST_RST_REL)
                begin
                    next_cur.lrb = scl_s;
                end
                if (start_req && (cur.state == ST_RST_REL || !cur.line_busy))
                begin
                    next_cur.master_select = 1'b1;
                    next_cur.trx = w_trx;
                    next_cur.bb = 1'b1;
                    next_cur.pin = 1'b1;
                    next_cur.line_busy = 1'b1;
                    next_cur.sda_drv = 1'b1;
                    next_cur.cnt = load_of(cur.m_val);
                    next_cur.state = ST_START_HOLD;
                end
                else if (wr_ctrl && !w_bb)
                begin
                    next_cur.master_select = w_mst;
                    next_cur.trx = w_trx;
                end
            end

            // hold after start before the first clock
            ST_START_HOLD:
            begin
                if (cnt_done)
                begin
                    next_cur.scl_drv = 1'b1;
                    next_cur.bitn = 4'h0;
                    next_cur.cnt = load_of(cur.n_val);
                    next_cur.state = ST_BIT_LOW;
                end
                else
                begin
                    next_cur.cnt = cur.cnt - 8'h01;
                end
            end

            ST_BIT_LOW:
            begin
                next_cur.scl_drv = 1'b1;
                if (cur.bitn < `ISRC_BITS_PER_WORD)
                begin
                    next_cur.sda_drv = cur.trx && !cur.shift[7];
                end
                else
                begin
                    // receiver answers with ack only when enabled
                    next_cur.sda_drv = !cur.trx && cur.ack_en;
                end
                if (cnt_done)
                begin
                    next_cur.scl_drv = 1'b0;
                    next_cur.cnt = load_of(cur.m_val);
                    next_cur.state = ST_BIT_HIGH;
                end
                else
                begin
                    next_cur.cnt = cur.cnt - 8'h01;
                end
            end

            // high period of m cycles, counted once the line is high
            ST_BIT_HIGH:
            begin
                if (!scl_s)
                begin
                    next_cur.cnt = load_of(cur.m_val);
                end
                else if (!cnt_done)
                begin
                    next_cur.cnt = cur.cnt - 8'h01;
                end
                else if (cur.bitn < `ISRC_BITS_PER_WORD)
                begin
                    next_cur.shift = {cur.shift[6:0], sda_s};
                    next_cur.bitn = cur.bitn + 4'h1;
                    next_cur.scl_drv = 1'b1;
                    next_cur.cnt = load_of(cur.n_val);
                    next_cur.state = ST_BIT_LOW;
                end
                else
                begin
                    // word end: clear pending and hold the clock low
                    next_cur.lrb = sda_s;
                    next_cur.rx_data = cur.shift;
                    next_cur.pin = 1'b0;
                    next_cur.scl_drv = 1'b1;
                    next_cur.sda_drv = 1'b0;
                    events[`ISRC_IRQ_WORD] = 1'b1;
                    next_cur.state = ST_WAIT;
                end
            end

            ST_WAIT:
            begin
                next_cur.scl_drv = 1'b1;
                if (stop_req)
                begin
                    // begin the stop with data pulled low
                    next_cur.pin = 1'b1;
                    next_cur.sda_drv = 1'b1;
                    next_cur.cnt = load_of(cur.n_val);
                    next_cur.state = ST_STOP_LOW;
                end
                else if (rst_req)
                begin
                    // data stays released while the clock is let go
                    next_cur.master_select = 1'b0;
                    next_cur.trx = 1'b0;
                    next_cur.pin = 1'b1;
                    next_cur.sda_drv = 1'b0;
                    next_cur.cnt = load_of(cur.n_val);
                    next_cur.state = ST_RST_LOW;
                end
                // resume waits a full low period before the clock rises
                else if (resume_req)
                begin
                    if (wr_data)
                    begin
                        next_cur.shift = wdata_i[7:0];
                    end
                    next_cur.pin = 1'b1;
                    next_cur.bitn = 4'h0;
                    next_cur.cnt = load_of(cur.n_val);
                    next_cur.state = ST_BIT_LOW;
                end
            end

            ST_STOP_LOW:
            begin
                next_cur.scl_drv = 1'b1;
                next_cur.sda_drv = 1'b1;
                if (cnt_done)
                begin
                    next_cur.scl_drv = 1'b0;
                    next_cur.state = ST_STOP_REL;
                end
                else
                begin
                    next_cur.cnt = cur.cnt - 8'h01;
                end
            end

            // another device may still stretch the clock
            ST_STOP_REL:
            begin
                if (scl_s)
                begin
                    next_cur.cnt = load_of(cur.m_val);
                    next_cur.state = ST_STOP_HIGH;
                end
            end

            // one high period before data rises
            ST_STOP_HIGH:
            begin
                if (!scl_s)
                begin
                    next_cur.state = ST_STOP_REL;
                end
                else if (!cnt_done)
                begin
                    next_cur.cnt = cur.cnt - 8'h01;
                end
                else
                begin
                    // data rises only after m high cycles
                    next_cur.sda_drv = 1'b0;
                    next_cur.bb = 1'b0;
                    next_cur.master_select = 1'b0;
                    next_cur.trx = 1'b0;
                    events[`ISRC_IRQ_STOP] = 1'b1;
                    next_cur.state = ST_IDLE;
                end
            end

            // low period before our clock is released
            ST_RST_LOW:
            begin
                next_cur.scl_drv = 1'b1;
                if (cnt_done)
                begin
                    // status busy drops as our clock pin lets go
                    next_cur.scl_drv = 1'b0;
                    next_cur.bb = 1'b0;
                    // no stop was sent, so the line stays busy
                    next_cur.line_busy = 1'b1;
                    events[`ISRC_IRQ_RST] = 1'b1;
                    next_cur.state = ST_RST_REL;
                end
                else
                begin
                    next_cur.cnt = cur.cnt - 8'h01;
                end
            end
        endcase

        // Hardware set wins over a write-one clear in the same cycle
        if (wr_irq_st)
        begin
            next_cur.irq_st = cur.irq_st & ~wdata_i[2:0];
        end
        next_cur.irq_st = next_cur.irq_st | events;
        next_cur.irq = |(next_cur.irq_st & next_cur.irq_msk);

        // Read data stands in the cycle after the strobe only
        next_cur.rdata = '0;
        if (rd_i)
        begin
            case (addr)
                `ISRC_A_CTRL:
                begin
                    next_cur.rdata[7:0] = {cur.master_select, cur.trx, cur.bb, cur.pin,
                                           cur.ack_en, 3'b000};
                end
                `ISRC_A_STAT:
                begin
                    next_cur.rdata[7:0] = {cur.master_select, cur.trx, cur.bb, cur.pin,
                                           1'b0, cur.line_busy, scl_s, cur.lrb};
                end
                `ISRC_A_DATA:
                begin
                    next_cur.rdata[7:0] = cur.rx_data;
                end
                `ISRC_A_CLK:
                begin
                    next_cur.rdata[15:0] = {cur.m_val, cur.n_val};
                end
                `ISRC_A_IRQ_ST:
                begin
                    next_cur.rdata[2:0] = cur.irq_st;
                end
                `ISRC_A_IRQ_MSK:
                begin
                    next_cur.rdata[2:0] = cur.irq_msk;
                end
                default:
                begin
                    next_cur.rdata = '0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            cur <= '0;
            cur.state <= ST_IDLE;
            cur.ack_en <= `ISRC_RST_ACK;
            cur.m_val <= `ISRC_RST_M;
            cur.n_val <= `ISRC_RST_N;
            cur.pin <= 1'b1;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Open drain: the pads only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_n_o = ~cur.scl_drv;
    assign sda_oe_n_o = ~cur.sda_drv;
    assign rdata_o = cur.rdata;
    assign irq_o = cur.irq;

endmodule // isrc_ctrl

//--- tb/isrc_ctrl_properties.sv
`include "isrc_regs.svh"
module isrc_ctrl_chk
#(
    parameter int ADDR_W = 8
)
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire isrc_pkg::isrc_word_t wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire isrc_pkg::isrc_word_t rdata_o,
    input wire logic irq_o,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe_n_o,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import isrc_pkg::*;
    typedef struct packed {
        isrc_cnt_t m;
        isrc_cnt_t n;
        logic [8:0] scl_lo;
        logic [8:0] line_hi;
        logic [8:0] sda_lo;
    } isrc_chk_s;
    isrc_chk_s cur;
    isrc_chk_s next_cur;

    // Saturates so a long idle never wraps back under m or n
    function automatic logic [8:0] isrc_bump(input logic [8:0] c, input logic run);
        return run ? c + {8'h00, ~&c} : 9'h000;
    endfunction

    always_comb
    begin
        next_cur = cur;
        if (wr_i && addr_i == ADDR_W'(`ISRC_A_CLK))
        begin
            next_cur.m = wdata_i[15:8];
            next_cur.n = wdata_i[7:0];
        end
        next_cur.scl_lo = isrc_bump(cur.scl_lo, !scl_oe_n_o);
        next_cur.line_hi = isrc_bump(cur.line_hi, scl_i);
        next_cur.sda_lo = isrc_bump(cur.sda_lo, !sda_oe_n_o);
    end

    always_ff @(posedge mclk_i)
        if (rst_i)
            cur <= '{m: `ISRC_RST_M, n: `ISRC_RST_N, default: '0};
        else
            cur <= next_cur;

    // ----------------------------------------------------------------
    // Port relations
    // ----------------------------------------------------------------
    default clocking chk_cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    reset_idle_a: assert property
        ($fell(rst_i) |-> scl_oe_n_o && sda_oe_n_o && !irq_o && rdata_o == '0)
        else $error("outputs not idle after reset");
    read_idle_a: assert property (!$past(rd_i) |-> rdata_o == '0)
        else $error("read data outside the read answer cycle");
    read_upper_a: assert property (rd_i |=> rdata_o[31:16] == 16'h0000)
        else $error("upper read data bits not zero");
    open_drain_a: assert property (!scl_o && !sda_o)
        else $error("pin output levels not low");
    clk_low_a: assert property (
        $rose(scl_oe_n_o) |-> cur.scl_lo >= {1'b0, cur.n})
        else $error("clock low period shorter than n");
    clk_high_a: assert property (
        $fell(scl_oe_n_o) |-> cur.line_hi >= {1'b0, cur.m})
        else $error("clock high period shorter than m");
    start_hold_a: assert property (
        $fell(scl_oe_n_o) && !sda_oe_n_o |-> cur.sda_lo >= {1'b0, cur.m})
        else $error("start hold shorter than m");
    stop_setup_a: assert property (
        $rose(sda_oe_n_o) && scl_i |-> cur.line_hi >= {1'b0, cur.m})
        else $error("stop raised before clock line high for m");
    irq_masked_a: assert property (
        wr_i && addr_i == ADDR_W'(`ISRC_A_IRQ_MSK) && wdata_i[2:0] == 3'h0 |-> ##2 !irq_o)
        else $error("interrupt high with all sources masked");
endmodule // isrc_ctrl_chk

bind isrc_ctrl isrc_ctrl_chk #(.ADDR_W(ADDR_W)) u_isrc_chk (.mclk_i(mclk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o));

//--- tb/isrc_i2c_peer.sv
module isrc_i2c_peer
(
    input wire logic mclk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic tx_i,
    input wire logic [7:0] tx_byte_i,
    input wire logic [3:0] stretch_i,
    output logic scl_pull_o,
    output logic sda_pull_o,
    output logic [7:0] rx_byte_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int bits = 0;
    logic done = 1'b0;

    initial
    begin
        scl_pull_o = 1'b0;
        sda_pull_o = 1'b0;
        rx_byte_o = 8'h00;
    end

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    always @(negedge sda_i)
        if (scl_i)
        begin
            bits = 0;
            done = 1'b0;
        end

    // A no-acknowledge ends sending so the line is free for the stop
    always @(posedge scl_i)
    begin
        if (bits < 8)
            rx_byte_o = {rx_byte_o[6:0], sda_i};
        else if (tx_i && sda_i)
            done = 1'b1;
        bits = bits + 1;
    end

    always @(negedge scl_i)
    begin
        if (bits >= 9)
            bits = 0;
        sda_pull_o = (tx_i && !done && bits < 8) ? !tx_byte_i[7 - bits] : (!tx_i && bits == 8);
        if (stretch_i != 4'h0)
        begin
            scl_pull_o <= 1'b1;
            repeat (stretch_i) @(posedge mclk_i);
            scl_pull_o <= 1'b0;
        end
    end
endmodule // isrc_i2c_peer

//--- tb/tb_top.sv
`include "isrc_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import isrc_pkg::*;
    logic mclk_i;
    logic rst_i;
    logic [7:0] addr_i;
    isrc_word_t wdata_i;
    logic wr_i;
    logic rd_i;
    isrc_word_t rdata_o;
    logic irq_o;
    logic scl_oe_n_o;
    logic sda_oe_n_o;
    logic scl_pull;
    logic sda_pull;
    logic tb_hold;
    logic peer_tx;
    logic [7:0] peer_byte;
    logic [7:0] peer_rx;
    logic [3:0] stretch;
    logic [1:0] seen;
    logic [7:0] b;
    isrc_word_t d;
    int seed;
    int n_fail = 0;
    int comparisons = 0;

    // Open-drain wires with pull-ups
    wire scl_line = scl_oe_n_o & ~scl_pull & ~tb_hold;
    wire sda_line = sda_oe_n_o & ~sda_pull;

    isrc_ctrl dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .scl_i(scl_line),
        .scl_o(), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_line), .sda_o(), .sda_oe_n_o(sda_oe_n_o));
    isrc_i2c_peer peer (.mclk_i(mclk_i), .scl_i(scl_line), .sda_i(sda_line), .tx_i(peer_tx),
        .tx_byte_i(peer_byte), .stretch_i(stretch), .scl_pull_o(scl_pull),
        .sda_pull_o(sda_pull), .rx_byte_o(peer_rx));

    initial
    begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    // ----------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------
    task automatic results();
        if (n_fail == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input isrc_word_t seen_v, input isrc_word_t exp);
        comparisons++;
        if (seen_v !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t ns: seen %h expected %h", $time, seen_v, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input isrc_word_t v);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output isrc_word_t v);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask

    function automatic isrc_word_t stat(input logic [3:0] ctl, input logic [2:0] low3);
        return {24'h00_0000, ctl, 1'b0, low3};
    endfunction

    // Skip two edges so a just-cleared request has left the output
    task automatic wait_irq(input int k);
        int t;
        repeat (2) @(posedge mclk_i);
        #1;
        for (t = 0; t < 2000 && irq_o !== 1'b1; t++)
            @(posedge mclk_i) #1;
        if (t == 2000)
        begin
            n_fail++;
            results();
        end
        rd(`ISRC_A_IRQ_ST, d);
        check(d, 32'h0000_0001 << k);
        wr(`ISRC_A_IRQ_ST, d);
    endtask

    initial
    begin
        #3_000_000;
        n_fail++;
        results();
    end

    initial
    begin
        seed = 32'h7896;
        rst_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = '0;
        tb_hold = 1'b0;
        peer_tx = 1'b0;
        peer_byte = 8'h00;
        stretch = 4'h0;
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd(`ISRC_A_CTRL, d);
        check(d, 32'h0000_0018);
        rd(`ISRC_A_CLK, d);
        check(d, 32'h0000_1418);
        rd(`ISRC_A_IRQ_MSK, d);
        check(d, 32'h0000_0000);
        rd(8'h20, d);
        check(d, 32'h0000_0000);
        rd(`ISRC_A_STAT, d);
        check(d & 32'hFFFF_FFFE, stat(4'b0001, 3'b010));
        // One link bit every 1000 ns when no device stretches the clock
        wr(`ISRC_A_CLK, 32'h0000_0404);
        rd(`ISRC_A_CLK, d);
        check(d, 32'h0000_0404);
        wr(`ISRC_A_IRQ_MSK, 32'h0000_0007);
        for (int i = 0; i < 3; i++)
        begin
            b = (i == 1) ? 8'hFF : (i == 2) ? 8'h00 : 8'($random(seed));
            stretch = (i == 1) ? 4'h0 : 4'(5 + ($random(seed) & 3));
            wr(`ISRC_A_DATA, {24'h00_0000, b});
            if (i == 0)
                wr(`ISRC_A_CTRL, 32'h0000_00F8);
            wait_irq(`ISRC_IRQ_WORD);
            check(peer_rx, b);
            rd(`ISRC_A_STAT, d);
            check(d, stat(4'b1110, 3'b100));
            check(scl_line, 1'b0);
        end
        // Another device holds the clock; pending bit set at once, other control bits left alone until the stop
        stretch = 4'h0;
        tb_hold <= 1'b1;
        wr(`ISRC_A_CTRL, 32'h0000_00D8);
        repeat (30) @(posedge mclk_i);
        check(sda_line, 1'b0);
        tb_hold <= 1'b0;
        wait_irq(`ISRC_IRQ_STOP);
        check({scl_line, sda_line}, 2'b11);
        rd(`ISRC_A_STAT, d);
        check(d & 32'h0000_00F0, 32'h0000_0010);
        b = 8'($random(seed));
        wr(`ISRC_A_DATA, {24'h00_0000, b});
        wr(`ISRC_A_CTRL, 32'h0000_00F8);
        wait_irq(`ISRC_IRQ_WORD);
        wr(`ISRC_A_IRQ_MSK, 32'h0000_0000);
        wr(`ISRC_A_CTRL, 32'h0000_0018);
        seen = 2'b00;
        repeat (40)
            @(posedge mclk_i) #1 seen = seen | {irq_o, ~sda_oe_n_o};
        check(seen, 2'b00);
        rd(`ISRC_A_IRQ_ST, d);
        check(d, 32'h0000_0004);
        rd(`ISRC_A_STAT, d);
        check(d, stat(4'b0001, 3'b111));
        wr(`ISRC_A_IRQ_MSK, 32'h0000_0007);
        repeat (2) @(posedge mclk_i);
        #1 check(irq_o, 1'b1);
        wr(`ISRC_A_IRQ_ST, 32'h0000_0004);
        peer_tx = 1'b1;
        peer_byte = 8'($random(seed));
        repeat (47) @(posedge mclk_i);
        wr(`ISRC_A_CTRL, 32'h0000_00B8);
        wait_irq(`ISRC_IRQ_WORD);
        rd(`ISRC_A_DATA, d);
        check(d, {24'h00_0000, peer_byte});
        // Resume through the pending bit, answering with no acknowledge
        wr(`ISRC_A_CTRL, 32'h0000_00B0);
        wait_irq(`ISRC_IRQ_WORD);
        rd(`ISRC_A_DATA, d);
        check(d, {24'h00_0000, peer_byte});
        rd(`ISRC_A_STAT, d);
        check(d & 32'h0000_0001, 32'h0000_0001);
        check(scl_line, 1'b0);
        wr(`ISRC_A_CTRL, 32'h0000_00D0);
        wait_irq(`ISRC_IRQ_STOP);
        check({scl_line, sda_line}, 2'b11);
        results();
    end
endmodule // tb_top
